// ---- src/tfp_pkg.sv ----
// Purpose: Shared constants for the timer flags, force and PWM block
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes: Offsets are byte addresses
package tfp_pkg;
	localparam int TFP_ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] TFP_OFS_CTRL = 8'h00;
	localparam logic [7:0] TFP_OFS_IEN = 8'h04;
	localparam logic [7:0] TFP_OFS_FLAGS = 8'h08;
	localparam logic [7:0] TFP_OFS_FORCE = 8'h0c;
	localparam logic [7:0] TFP_OFS_DUTY_A = 8'h10;
	localparam logic [7:0] TFP_OFS_DUTY_B = 8'h14;
	localparam logic [7:0] TFP_OFS_PWM_CNT = 8'h18;
	localparam logic [7:0] TFP_OFS_PWM_BUF = 8'h1c;
	localparam logic [7:0] TFP_OFS_SHARED_PRESCALER_VALUE = 8'h20;
	localparam logic [7:0] TFP_OFS_MAIN_CNT = 8'h24;
	localparam logic [7:0] TFP_OFS_CMP1 = 8'h28;
	localparam logic [7:0] TFP_OFS_ACC_CNT = 8'h3c;
	// Control register fields
	localparam int TFP_CTRL_SEL_LSB = 0;
	localparam int TFP_CTRL_ACC_EN = 3;
	localparam int TFP_CTRL_ACC_MODE = 4;
	localparam int TFP_CTRL_ACC_EDGE = 5;
	localparam int TFP_CTRL_SHARED_SEL = 6;
	localparam int TFP_CTRL_ACT_LSB = 8;
	localparam int TFP_CTRL_EDGE_LSB = 16;
	localparam logic [31:0] TFP_CTRL_MASK = 32'h00ffff7f;
	// Event flag positions
	localparam int TFP_FLG_SHARED = 15;
	localparam int TFP_FLG_OC_LSB = 11;
	localparam int TFP_FLG_IC_LSB = 8;
	localparam int TFP_FLG_TOF = 7;
	localparam int TFP_FLG_PAOV = 5;
	localparam int TFP_FLG_PAI = 4;
	localparam logic [15:0] TFP_FLAG_MASK = 16'hffb0;
	// Force and PWM control fields
	localparam int TFP_FOC_LSB = 11;
	localparam int TFP_PW_FORCE_A = 9;
	localparam int TFP_PW_FORCE_B = 8;
	localparam int TFP_PW_CLKOUT = 7;
	localparam int TFP_PW_SEL_LSB = 4;
	localparam int TFP_PW_SLOW_A = 3;
	localparam int TFP_PW_SLOW_B = 2;
	localparam int TFP_PW_LVL_A = 1;
	localparam int TFP_PW_LVL_B = 0;
	localparam logic [15:0] TFP_PWM_CONTROL_MASK = 16'h03ff;
	// PWM field positions in the PWM counter
	localparam int TFP_FAST_LSB = 0;
	localparam int TFP_SLOW_LSB = 7;
	// Reset values
	localparam logic [15:0] TFP_CMP_RST = 16'hffff;
	localparam logic [15:0] TFP_FLAGS_RST = 16'h0000;
	localparam logic [15:0] TFP_BUF_RST = 16'h0000;
	localparam logic [8:0] TFP_SHARED_PRESCALER_VALUE_RST = 9'h000;
	// Prescaler tap bases and the external clock code
	localparam logic [8:0] TFP_MAIN_DIV_BASE = 9'h004;
	localparam logic [8:0] TFP_PWM_DIV_BASE = 9'h002;
	localparam logic [2:0] TFP_SEL_EXT = 3'h7;
	localparam logic [1:0] TFP_OC1_ACTION = 2'h1;
	// AXI responses
	localparam logic [1:0] TFP_RESP_OKAY = 2'h0;
	localparam logic [1:0] TFP_RESP_SLVERR = 2'h2;
endpackage

// ---- src/tfp_edge_if.sv ----
// Purpose: Carries a synchronised pin level and its edges
// Assumes: Driven by tfp_pin_sync on the system clock
// Notes: Edges are one-cycle pulses
`timescale 1ns/100ps
interface tfp_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// ---- src/tfp_pin_sync.sv ----
// Purpose: Three-stage pin synchroniser with edge detection
// Assumes: Pin is asynchronous to clk_sys_i
// Notes: A change counts once stages two and three agree
`timescale 1ns/100ps
module tfp_pin_sync (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic pin_i,
	tfp_edge_if.src edge_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	logic lvl_d;

	assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
	assign edge_o.level = lvl_q;
	assign edge_o.rise = lvl_d & ~lvl_q;
	assign edge_o.fall = ~lvl_d & lvl_q;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end
endmodule

// ---- src/tfp_timer.sv ----
// Purpose: Timer prescalers, main counter, event flags, compare force and two-channel PWM
// Assumes: AXI4-Lite slave, 32-bit data, one register per word; single clock
// Notes: Pin inputs pass tfp_pin_sync; event flags clear by writing one
// Functional notes
// - Main counter clock: divide by 4 to 256, or external clock for code 7
// - Interrupt request while any flag and its enable are both set
// - Shared flag: compare 5 match, or selected pin edge in capture mode
// - Compare flags 1 to 4 set when main counter equals compare value
// - Capture flags 1 to 3 set on the configured edge at their pin
// - Main wrap flag sets when counter goes from all ones to zero
// - Accumulator wrap flag sets when 8-bit accumulator goes from 0xff to zero
// - Accumulator input flag: active edge, or end of gated period
// - Writing one to a force bit does the pin action, no flag set
// - Channel A force drives force level, over PWM and clock output
// - Channel B force drives force level instead of PWM waveform
// - Clock output enable puts main counter input clock on channel A
// - PWM counter clock: divide by 2 to 128, or external clock for code 7
// - Channel A period is 256 or 32768 increments by slow/fast select
// - Channel B period is 256 or 32768 increments by slow/fast select
// - Force level zero drives low, one drives high
// - Duty zero is always low, 0x80 half, 0xff high 255/256
// - PWM unit has its own 16-bit free-running counter
// - Read-only duty buffers hold the duty in use, reset to zero
// - Prescaler is 9 bits readable low, upper bits read zero
// - Main counter is a 16-bit free-running time base
// - Action code: 00 none, 01 toggle, 10 clear, 11 set
// - Function select: zero compare 5, one capture 4
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module tfp_timer import tfp_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [TFP_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [TFP_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [2:0] capture_pin_i,
	input wire logic shared_pin_i,
	input wire logic accumulator_input_pin_i,
	input wire logic ext_clock_pin_i,
	output logic [4:0] compare_pin_o,
	output logic shared_pin_oe_o,
	output logic pwm_a_o,
	output logic pwm_b_o,
	output logic irq_o
);
	// Bus state
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q;
	logic [7:0] waddr_q;
	logic [3:0] wstrb_q;
	// Block state
	logic [31:0] ctrl_q;
	logic [15:0] ien_q, flags_q, pwm_control_q, cnt_q, pwm_cnt_q;
	logic [7:0] duty_a_q, duty_b_q, acc_q;
	logic [8:0] ps_q;
	logic adv_q, pwm_adv_q, shared_oe_q, pwm_a_q, pwm_b_q, irq_q;
	logic [15:0] cmp_q [5];
	logic [7:0] buf_q [2];
	logic [4:0] oc_q;

	// Pin synchronisers: 0..2 capture, 3 shared, 4 accumulator, 5 external clock
	logic [5:0] pins_w, lvl_w, rise_w, fall_w;
	tfp_edge_if eif [6] ();
	assign pins_w = {ext_clock_pin_i, accumulator_input_pin_i, shared_pin_i, capture_pin_i};
	for (genvar g = 0; g < 6; g++) begin : g_sync
		tfp_pin_sync u_sync (
			.clk_sys_i(clk_sys_i),
			.reset_i(reset_i),
			.pin_i(pins_w[g]),
			.edge_o(eif[g])
		);
		assign lvl_w[g] = eif[g].level;
		assign rise_w[g] = eif[g].rise;
		assign fall_w[g] = eif[g].fall;
	end

	// Write decode
	logic wr_fire_w, wr_ctrl_w, wr_ien_w, wr_flags_w, wr_force_w, wr_duty_a_w, wr_duty_b_w, wr_hit_w;
	logic [31:0] wmask_w, wval_w;
	logic [4:0] wr_cmp_w;
	assign wr_fire_w = ~awready_q & ~wready_q & ~bvalid_q;
	assign wmask_w = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wval_w = wdata_q & wmask_w;
	assign wr_ctrl_w = wr_fire_w & (waddr_q == TFP_OFS_CTRL);
	assign wr_ien_w = wr_fire_w & (waddr_q == TFP_OFS_IEN);
	assign wr_flags_w = wr_fire_w & (waddr_q == TFP_OFS_FLAGS);
	assign wr_force_w = wr_fire_w & (waddr_q == TFP_OFS_FORCE);
	assign wr_duty_a_w = wr_fire_w & (waddr_q == TFP_OFS_DUTY_A);
	assign wr_duty_b_w = wr_fire_w & (waddr_q == TFP_OFS_DUTY_B);
	for (genvar c = 0; c < 5; c++) begin : g_cmp_dec
		assign wr_cmp_w[c] = wr_fire_w & (waddr_q == 8'(TFP_OFS_CMP1 + 8'(4 * c)));
	end
	// Read-only registers accept writes silently
	assign wr_hit_w = (waddr_q <= TFP_OFS_ACC_CNT) & (waddr_q[1:0] == 2'h0);

	// Prescaler taps
	logic [2:0] main_sel_w, pwm_sel_w;
	logic [8:0] main_mask_w, pwm_mask_w;
	logic main_tick_w, pwm_tick_w, main_clk_lvl_w;
	assign main_sel_w = ctrl_q[TFP_CTRL_SEL_LSB +: 3];
	assign pwm_sel_w = pwm_control_q[TFP_PW_SEL_LSB +: 3];
	assign main_mask_w = 9'((TFP_MAIN_DIV_BASE << main_sel_w) - 9'h001);
	assign pwm_mask_w = 9'((TFP_PWM_DIV_BASE << pwm_sel_w) - 9'h001);
	assign main_tick_w = (main_sel_w == TFP_SEL_EXT) ? rise_w[5] : &(ps_q | ~main_mask_w);
	assign pwm_tick_w = (pwm_sel_w == TFP_SEL_EXT) ? rise_w[5] : &(ps_q | ~pwm_mask_w);
	assign main_clk_lvl_w = (main_sel_w == TFP_SEL_EXT) ? lvl_w[5] : ps_q[{1'b0, main_sel_w} + 4'h1];

	// Compare matches and capture edges
	logic shared_sel_w;
	logic [4:0] match_w, foc_w, oc_d;
	logic [3:0] cap_w;
	assign shared_sel_w = ctrl_q[TFP_CTRL_SHARED_SEL];
	assign foc_w = wr_force_w ? wval_w[TFP_FOC_LSB +: 5] : 5'h00;
	for (genvar c = 0; c < 5; c++) begin : g_oc
		logic [1:0] act_w;
		logic fire_w;
		if (c == 0) begin : g_first
			assign act_w = TFP_OC1_ACTION;
		end else begin : g_rest
			assign act_w = ctrl_q[TFP_CTRL_ACT_LSB + 2 * (c - 1) +: 2];
		end
		assign match_w[c] = adv_q & (cnt_q == cmp_q[c]) & ((c != 4) | ~shared_sel_w);
		assign fire_w = match_w[c] | foc_w[c];
		assign oc_d[c] = ~fire_w ? oc_q[c] :
			(act_w == 2'h1) ? ~oc_q[c] :
			(act_w == 2'h2) ? 1'b0 :
			(act_w == 2'h3) ? 1'b1 : oc_q[c];
	end
	for (genvar c = 0; c < 4; c++) begin : g_ic
		logic [1:0] ec_w;
		assign ec_w = ctrl_q[TFP_CTRL_EDGE_LSB + 2 * c +: 2];
		assign cap_w[c] = (ec_w[0] & rise_w[c]) | (ec_w[1] & fall_w[c]);
	end

	// Pulse accumulator
	logic acc_en_w, acc_mode_w, acc_edge_w, acc_ev_w, acc_gate_w, acc_inc_w;
	assign acc_en_w = ctrl_q[TFP_CTRL_ACC_EN];
	assign acc_mode_w = ctrl_q[TFP_CTRL_ACC_MODE];
	assign acc_edge_w = ctrl_q[TFP_CTRL_ACC_EDGE];
	// Active edge in counting mode is also the closing edge of a gated period
	assign acc_ev_w = acc_en_w & (acc_edge_w ? rise_w[4] : fall_w[4]);
	assign acc_gate_w = lvl_w[4] ^ acc_edge_w;
	assign acc_inc_w = acc_en_w & (acc_mode_w ? (acc_gate_w & main_tick_w) : acc_ev_w);

	// Event flags
	logic [15:0] set_w, clr_w, flags_d;
	assign set_w[TFP_FLG_SHARED] = shared_sel_w ? cap_w[3] : match_w[4];
	assign set_w[TFP_FLG_OC_LSB +: 4] = match_w[3:0];
	assign set_w[TFP_FLG_IC_LSB +: 3] = cap_w[2:0];
	assign set_w[TFP_FLG_TOF] = main_tick_w & (cnt_q == 16'hffff);
	assign set_w[6] = 1'b0;
	assign set_w[TFP_FLG_PAOV] = acc_inc_w & (acc_q == 8'hff);
	assign set_w[TFP_FLG_PAI] = acc_ev_w;
	assign set_w[3:0] = 4'h0;
	assign clr_w = wr_flags_w ? wval_w[15:0] : 16'h0000;
	// A set in the clearing cycle wins
	assign flags_d = ((flags_q & ~clr_w) | set_w) & TFP_FLAG_MASK;

	// PWM channels, index 0 is A
	logic [1:0] slow_w, start_w, wave_w;
	logic [7:0] duty_w [2];
	assign slow_w = {pwm_control_q[TFP_PW_SLOW_B], pwm_control_q[TFP_PW_SLOW_A]};
	assign duty_w[0] = duty_a_q;
	assign duty_w[1] = duty_b_q;
	for (genvar p = 0; p < 2; p++) begin : g_pwm
		logic [7:0] field_w;
		logic [7:0] eff_w;
		// Slow period uses bits 14:7, fast period bits 7:0
		assign field_w = slow_w[p] ? pwm_cnt_q[TFP_SLOW_LSB +: 8] : pwm_cnt_q[TFP_FAST_LSB +: 8];
		assign start_w[p] = pwm_adv_q & (slow_w[p] ? (pwm_cnt_q[14:0] == 15'h0000) : (field_w == 8'h00));
		assign eff_w = start_w[p] ? duty_w[p] : buf_q[p];
		assign wave_w[p] = field_w < eff_w;
		always_ff @(posedge clk_sys_i) begin
			if (reset_i) begin
				buf_q[p] <= TFP_BUF_RST[7:0];
			end else if (start_w[p]) begin
				buf_q[p] <= duty_w[p];
			end
		end
	end

	logic pwm_a_d, pwm_b_d;
	assign pwm_a_d = pwm_control_q[TFP_PW_FORCE_A] ? pwm_control_q[TFP_PW_LVL_A] :
		pwm_control_q[TFP_PW_CLKOUT] ? main_clk_lvl_w : wave_w[0];
	assign pwm_b_d = pwm_control_q[TFP_PW_FORCE_B] ? pwm_control_q[TFP_PW_LVL_B] : wave_w[1];

	// Read mux
	logic [7:0] raddr_w;
	logic [31:0] rmux_w;
	logic rhit_w;
	logic [2:0] cidx_w;
	assign raddr_w = s_axi_araddr_i;
	assign cidx_w = 3'((raddr_w - TFP_OFS_CMP1) >> 2);
	assign rhit_w = (raddr_w <= TFP_OFS_ACC_CNT) & (raddr_w[1:0] == 2'h0);
	assign rmux_w = (raddr_w == TFP_OFS_CTRL) ? ctrl_q :
		(raddr_w == TFP_OFS_IEN) ? {16'h0000, ien_q} :
		(raddr_w == TFP_OFS_FLAGS) ? {16'h0000, flags_q} :
		(raddr_w == TFP_OFS_FORCE) ? {16'h0000, pwm_control_q} :
		(raddr_w == TFP_OFS_DUTY_A) ? {24'h000000, duty_a_q} :
		(raddr_w == TFP_OFS_DUTY_B) ? {24'h000000, duty_b_q} :
		(raddr_w == TFP_OFS_PWM_CNT) ? {16'h0000, pwm_cnt_q} :
		(raddr_w == TFP_OFS_PWM_BUF) ? {16'h0000, buf_q[0], buf_q[1]} :
		(raddr_w == TFP_OFS_SHARED_PRESCALER_VALUE) ? {23'h000000, ps_q} :
		(raddr_w == TFP_OFS_MAIN_CNT) ? {16'h0000, cnt_q} :
		(raddr_w == TFP_OFS_ACC_CNT) ? {24'h000000, acc_q} :
		(rhit_w && raddr_w >= TFP_OFS_CMP1) ? {16'h0000, cmp_q[cidx_w]} : 32'h00000000;

	// AXI4-Lite handshakes
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= TFP_RESP_OKAY;
			waddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && awready_q) begin
				awready_q <= 1'b0;
				waddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && wready_q) begin
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_fire_w) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit_w ? TFP_RESP_OKAY : TFP_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= TFP_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else if (s_axi_arvalid_i && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rmux_w;
			rresp_q <= rhit_w ? TFP_RESP_OKAY : TFP_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Software-written registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ctrl_q <= 32'h00000000;
			ien_q <= 16'h0000;
			pwm_control_q <= 16'h0000;
			duty_a_q <= 8'h00;
			duty_b_q <= 8'h00;
		end else begin
			if (wr_ctrl_w) begin
				ctrl_q <= ((ctrl_q & ~wmask_w) | wval_w) & TFP_CTRL_MASK;
			end
			if (wr_ien_w) begin
				ien_q <= ((ien_q & ~wmask_w[15:0]) | wval_w[15:0]) & TFP_FLAG_MASK;
			end
			if (wr_force_w) begin
				pwm_control_q <= ((pwm_control_q & ~wmask_w[15:0]) | wval_w[15:0]) & TFP_PWM_CONTROL_MASK;
			end
			if (wr_duty_a_w && wstrb_q[0]) begin
				duty_a_q <= wdata_q[7:0];
			end
			if (wr_duty_b_w && wstrb_q[0]) begin
				duty_b_q <= wdata_q[7:0];
			end
		end
	end

	for (genvar c = 0; c < 5; c++) begin : g_cmp_reg
		always_ff @(posedge clk_sys_i) begin
			if (reset_i) begin
				cmp_q[c] <= TFP_CMP_RST;
			end else if (wr_cmp_w[c]) begin
				cmp_q[c] <= (cmp_q[c] & ~wmask_w[15:0]) | wval_w[15:0];
			end
		end
	end

	// Counters
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ps_q <= TFP_SHARED_PRESCALER_VALUE_RST;
			cnt_q <= 16'h0000;
			adv_q <= 1'b0;
			acc_q <= 8'h00;
			pwm_cnt_q <= 16'h0000;
			pwm_adv_q <= 1'b0;
		end else begin
			ps_q <= ps_q + 9'h001;
			adv_q <= main_tick_w;
			pwm_adv_q <= pwm_tick_w;
			if (main_tick_w) begin
				cnt_q <= cnt_q + 16'h0001;
			end
			if (acc_inc_w) begin
				acc_q <= acc_q + 8'h01;
			end
			if (pwm_tick_w) begin
				pwm_cnt_q <= pwm_cnt_q + 16'h0001;
			end
		end
	end

	// Flags, pins and interrupt request
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			flags_q <= TFP_FLAGS_RST;
			oc_q <= 5'h00;
			shared_oe_q <= 1'b0;
			pwm_a_q <= 1'b0;
			pwm_b_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			oc_q <= oc_d;
			shared_oe_q <= ~shared_sel_w;
			pwm_a_q <= pwm_a_d;
			pwm_b_q <= pwm_b_d;
			irq_q <= |(flags_d & ien_q);
		end
	end

	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rresp_o = rresp_q;
	assign s_axi_rdata_o = rdata_q;
	assign compare_pin_o = oc_q;
	assign shared_pin_oe_o = shared_oe_q;
	assign pwm_a_o = pwm_a_q;
	assign pwm_b_o = pwm_b_q;
	assign irq_o = irq_q;
endmodule

// ---- sim/tfp_timer_checker.sv ----
// Purpose: Port-level assertions for tfp_timer
// Assumes: Write address and write data are offered together
// Notes: Tracks written force and enable words from the bus
`timescale 1ns/100ps
module tfp_timer_checker import tfp_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [TFP_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic pwm_a_o,
	input wire logic pwm_b_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	logic [15:0] pwm_control_q;
	logic [15:0] ien_q;
	wire logic wr_go;
	assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pwm_control_q <= 16'h0000;
			ien_q <= 16'h0000;
		end else begin
			if (wr_go && s_axi_awaddr_i == TFP_OFS_FORCE) pwm_control_q <= s_axi_wdata_i[15:0];
			if (wr_go && s_axi_awaddr_i == TFP_OFS_IEN) ien_q <= s_axi_wdata_i[15:0];
		end
	end
	sequence s_fa_held;
		(pwm_control_q[9] && $stable(pwm_control_q))[*4];
	endsequence
	sequence s_fb_held;
		(pwm_control_q[8] && $stable(pwm_control_q))[*4];
	endsequence
	property p_wr_answer;
		wr_go |-> ##[1:2] s_axi_bvalid_o;
	endproperty
	property p_rd_answer;
		s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o;
	endproperty
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	property p_b_busy;
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
	endproperty
	property p_force_a;
		s_fa_held |-> pwm_a_o == pwm_control_q[1];
	endproperty
	property p_force_b;
		s_fb_held |-> pwm_b_o == pwm_control_q[0];
	endproperty
	property p_irq_masked;
		(ien_q == 16'h0000 && $stable(ien_q))[*4] |-> !irq_o;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	a_b_busy: assert property (p_b_busy) else $error("write ready during response");
	a_force_a: assert property (p_force_a) else $error("channel A not forced");
	a_force_b: assert property (p_force_b) else $error("channel B not forced");
	a_irq_masked: assert property (p_irq_masked) else $error("request while masked");
endmodule
bind tfp_timer tfp_timer_checker i_chk (.*);

// ---- sim/tfp_pins_model.sv ----
// Purpose: Far-side pin model for the timer
// Assumes: Bench asks for pin changes one cycle at a time
// Notes: External clock rests low while not running
`timescale 1ns/100ps
module tfp_pins_model (
	input wire logic clk_sys_i,
	input wire logic [4:0] toggle_i,
	input wire logic ext_run_i,
	input wire logic shared_oe_i,
	input wire logic shared_out_i,
	output logic [2:0] capture_pin_o,
	output logic shared_pin_o,
	output logic acc_pin_o,
	output logic ext_clock_o
);
	logic [4:0] lvl_q = 5'h00;
	logic [2:0] div_q = 3'h0;
	logic ext_q = 1'b0;
	always @(posedge clk_sys_i) begin
		lvl_q <= lvl_q ^ toggle_i;
		div_q <= div_q + 3'h1;
		ext_q <= ext_run_i & div_q[2];
	end
	assign capture_pin_o = lvl_q[2:0];
	// Device owns the shared pin while enabled
	assign shared_pin_o = shared_oe_i ? shared_out_i : lvl_q[3];
	assign acc_pin_o = lvl_q[4];
	assign ext_clock_o = ext_q;
endmodule

// ---- sim/tb_tfp_timer.sv ----
// Purpose: Self-checking bench for tfp_timer
// Assumes: PWM prescale 0 gives 512-cycle fast periods
// Notes: External clock from the pin model ticks every 8 cycles
`timescale 1ns/100ps
module tb_tfp_timer;
	import tfp_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [2:0] capture_pin_i;
	logic shared_pin_i, accumulator_input_pin_i, ext_clock_pin_i;
	logic [4:0] compare_pin_o;
	logic shared_pin_oe_o, pwm_a_o, pwm_b_o, irq_o;
	logic [4:0] tg = 5'h00;
	logic ext_run = 1'b0;
	logic [31:0] v, w, resp;
	int n_errors = 0;
	int checks = 0;
	int seed = 32'hd8d94615;
	int ha, hb;
	always #50 clk_sys_i = ~clk_sys_i;
	tfp_timer i_dut (.*);
	tfp_pins_model i_pins (.clk_sys_i, .toggle_i(tg), .ext_run_i(ext_run), .shared_oe_i(shared_pin_oe_o),
		.shared_out_i(compare_pin_o[4]), .capture_pin_o(capture_pin_i), .shared_pin_o(shared_pin_i),
		.acc_pin_o(accumulator_input_pin_i), .ext_clock_o(ext_clock_pin_i));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o === 1'b1) break;
		end
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
		if (n == 60) n_errors++;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o === 1'b1) break;
		end
		v = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
		if (n == 60) n_errors++;
	endtask
	task automatic tog(input logic [4:0] b);
		@(posedge clk_sys_i);
		tg <= b;
		@(posedge clk_sys_i);
		tg <= 5'h00;
		repeat (8) @(posedge clk_sys_i);
	endtask
	// High cycles over two fast periods, two clocks per step
	function automatic logic [31:0] exp_high(input logic [7:0] d);
		return {22'h000000, d, 2'h0};
	endfunction
	// Pin level after a forced action
	function automatic logic [31:0] exp_act(input logic [1:0] code, input logic old);
		return {31'h00000000, code == 2'h0 ? old : code == 2'h1 ? ~old : code[0]};
	endfunction
	// Ticks seen over about sixteen periods of the divider
	task automatic meas(input logic [7:0] a, input int div);
		rd(a);
		w = v;
		repeat (16 * div - 4) @(posedge clk_sys_i);
		rd(a);
		w = (v - w) & 32'hffff;
		chk({31'h0, w >= 15 && w <= 17}, 32'h1);
	endtask
	task automatic final_report;
		$display("counts: %0d checks, %0d errors", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#(60000 * 100);
		n_errors++;
		final_report;
	end
	initial begin
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(TFP_OFS_FLAGS);
		chk(v, 32'h0);
		rd(TFP_OFS_PWM_BUF);
		chk(v, 32'h0);
		rd(TFP_OFS_SHARED_PRESCALER_VALUE);
		chk(v & 32'hfffffe00, 32'h0);
		rd(8'h40);
		chk(resp, 32'h2);
		wr(8'h02, 32'h1);
		chk(resp, 32'h2);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			ext_run <= (i == 7);
			wr(TFP_OFS_CTRL, i);
			meas(TFP_OFS_MAIN_CNT, i == 7 ? 8 : 4 << i);
			wr(TFP_OFS_FORCE, i << 4);
			meas(TFP_OFS_PWM_CNT, i == 7 ? 8 : 2 << i);
		end
		ext_run <= 1'b0;
		$display("test rates done");
		wr(TFP_OFS_CTRL, 32'h0);
		wr(TFP_OFS_FLAGS, 32'hffff);
		rd(TFP_OFS_MAIN_CNT);
		wr(TFP_OFS_CMP1, (v + 40) & 32'hffff);
		wr(TFP_OFS_CMP1 + 8'h10, (v + 40) & 32'hffff);
		repeat (200) @(posedge clk_sys_i);
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h8800, 32'h8800);
		wr(TFP_OFS_IEN, 32'h800);
		repeat (3) @(posedge clk_sys_i);
		chk(irq_o, 32'h1);
		wr(TFP_OFS_FLAGS, 32'h0);
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h800, 32'h800);
		wr(TFP_OFS_FLAGS, 32'h800);
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h800, 32'h0);
		chk(irq_o, 32'h0);
		wr(TFP_OFS_IEN, 32'h0);
		$display("test flags done");
		for (int c = 0; c < 4; c++) begin
			wr(TFP_OFS_CTRL, c << 8);
			w = compare_pin_o[1];
			wr(TFP_OFS_FORCE, 32'h1000);
			repeat (3) @(posedge clk_sys_i);
			chk(compare_pin_o[1], exp_act(c[1:0], w[0]));
		end
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h1000, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(TFP_OFS_CTRL, c << 16);
			wr(TFP_OFS_FLAGS, 32'hffff);
			tog(5'h01);
			rd(TFP_OFS_FLAGS);
			chk(v & 32'h100, {c[0], 8'h00});
			wr(TFP_OFS_FLAGS, 32'hffff);
			tog(5'h01);
			rd(TFP_OFS_FLAGS);
			chk(v & 32'h100, {c[1], 8'h00});
		end
		wr(TFP_OFS_CTRL, 32'h400040);
		wr(TFP_OFS_FLAGS, 32'hffff);
		chk(shared_pin_oe_o, 32'h0);
		tog(5'h08);
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h8000, 32'h8000);
		wr(TFP_OFS_CTRL, 32'h0);
		wr(TFP_OFS_FLAGS, 32'hffff);
		chk(shared_pin_oe_o, 32'h1);
		$display("test compare capture done");
		wr(TFP_OFS_CTRL, 32'h28);
		wr(TFP_OFS_FLAGS, 32'hffff);
		tog(5'h10);
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h30, 32'h10);
		repeat (254) begin
			tog(5'h10);
			tog(5'h10);
		end
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h20, 32'h0);
		tog(5'h10);
		tog(5'h10);
		rd(TFP_OFS_FLAGS);
		chk(v & 32'h20, 32'h20);
		wr(TFP_OFS_CTRL, 32'h0);
		$display("test accumulator done");
		for (int k = 0; k < 4; k++) begin
			w = k == 0 ? 32'h0 : k == 1 ? 32'h80 : k == 2 ? 32'hff : $random(seed) & 32'hff;
			wr(TFP_OFS_FORCE, 32'h0);
			wr(TFP_OFS_DUTY_A, w);
			wr(TFP_OFS_DUTY_B, w ^ 32'hff);
			repeat (600) @(posedge clk_sys_i);
			ha = 0;
			hb = 0;
			repeat (1024) begin
				@(posedge clk_sys_i);
				if (pwm_a_o === 1'b1) ha++;
				if (pwm_b_o === 1'b1) hb++;
			end
			chk(ha, exp_high(w[7:0]));
			chk(hb, exp_high(~w[7:0]));
			rd(TFP_OFS_PWM_BUF);
			chk(v & 32'hffff, {16'h0, w[7:0], ~w[7:0]});
		end
		for (int k = 0; k < 4; k++) begin
			wr(TFP_OFS_FORCE, 32'h380 | k);
			repeat (3) @(posedge clk_sys_i);
			chk(pwm_a_o, k[1]);
			chk(pwm_b_o, k[0]);
		end
		wr(TFP_OFS_FORCE, 32'h80);
		ha = 0;
		w = pwm_a_o;
		repeat (400) begin
			@(posedge clk_sys_i);
			if (pwm_a_o === 1'b1 && w[0] === 1'b0) ha++;
			w = pwm_a_o;
		end
		chk({31'h0, ha >= 99 && ha <= 101}, 32'h1);
		$display("test pwm done");
		final_report;
	end
endmodule
